// >>> hdl/isp_consts.svh
// Offsets, bit positions and reset values of the interrupt source block
`ifndef ISP_CONSTS_SVH
`define ISP_CONSTS_SVH
`define ISP_OFF_RCPC   8'h00
`define ISP_OFF_MAIN   8'h04
`define ISP_OFF_SECOND 8'h08
`define ISP_OFF_THIRD  8'h0C
`define ISP_OFF_T0LO   8'h10
`define ISP_OFF_T0HI   8'h14
`define ISP_OFF_T0CTL  8'h18
`define ISP_OFF_PINS   8'h1C
`define ISP_OFF_SVC    8'h20
`define ISP_RCPC_PRIORITY_LEVEL_ENABLE  7
`define ISP_RCPC_WMASK 8'h93
`define ISP_RCPC_RST   8'h1C
`define ISP_MAIN_GIE   7
`define ISP_MAIN_PERIPHERAL_IRQ_ENABLE  6
`define ISP_MAIN_TIMER0_IRQ_ENABLE  5
`define ISP_MAIN_E0IE  4
`define ISP_MAIN_PCIE  3
`define ISP_MAIN_T0IF  2
`define ISP_MAIN_E0IF  1
`define ISP_MAIN_PCIF  0
`define ISP_SEC_EDG0   6
`define ISP_SEC_T0IP   2
`define ISP_SEC_PCIP   0
`define ISP_SEC_MASK   8'h75
`define ISP_SEC_RST    8'h75
`define ISP_THR_E2IP   7
`define ISP_THR_E1IP   6
`define ISP_THR_E2IE   4
`define ISP_THR_E1IE   3
`define ISP_THR_E2IF   1
`define ISP_THR_E1IF   0
`define ISP_THR_MASK   8'hDB
`define ISP_THR_RST    8'hC0
`define ISP_T0_RUN     0
`define ISP_T0_MODE    1
`endif

// >>> hdl/isp_pkg.sv
// Types shared by the interrupt source block
package isp_pkg;
  typedef logic [7:0] isp_byte_t;
  typedef enum logic {ISP_T0_8BIT, ISP_T0_16BIT} isp_t0_mode_t;
endpackage

// >>> hdl/isp_ctrl.sv
// Interrupt sources, priority routing, wake and context save with APB access
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "isp_consts.svh"
module isp_ctrl
  import isp_pkg::*;
#(
  parameter int PC_W  = 21,
  parameter int DEPTH = 31
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic [7:0]      paddr,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     pwdata,
  output logic                 pready,
  output logic [31:0]          prdata,
  output logic                 pslverr,
  input  wire logic [7:0]      pin_bank_b,
  input  wire logic            periph_req,
  input  wire logic            periph_prio,
  input  wire logic            core_sleeping,
  input  wire logic            isr_return,
  input  wire logic [PC_W-1:0] core_pc,
  input  wire logic [7:0]      working_register,
  input  wire logic [7:0]      core_status,
  input  wire logic [7:0]      bank_select_register,
  output logic                 irq_entry,
  output logic                 irq_entry_high,
  output logic                 core_wake,
  output logic [PC_W-1:0]      return_pc,
  output logic [7:0]           shadow_working_register,
  output logic [7:0]           shadow_status,
  output logic [7:0]           shadow_bsr
);
  localparam int SP_W = $clog2(DEPTH + 1);

  typedef struct packed {
    isp_byte_t                  rcpc;
    isp_byte_t                  main;
    isp_byte_t                  second;
    isp_byte_t                  third;
    isp_byte_t                  t0lo;
    isp_byte_t                  t0hi;
    logic [1:0]                 t0ctl;
    logic [7:0]                 sync1;
    logic [7:0]                 sync2;
    logic [2:0]                 prev;
    logic [3:0]                 pc_latch;
    logic [DEPTH-1:0][PC_W-1:0] stk;
    logic [SP_W-1:0]            sp;
    logic                       in_high;
    logic                       in_low;
    logic [PC_W-1:0]            ret_pc;
    isp_byte_t                  sh_working_register;
    isp_byte_t                  sh_stat;
    isp_byte_t                  sh_bsr;
    logic                       entry;
    logic                       entry_high;
    logic                       wake;
    logic                       pready;
    logic [31:0]                prdata;
    logic                       pslverr;
  } isp_state_t;

  isp_state_t state_reg;
  isp_state_t state_next;

  logic       wr;
  logic       rd_done;
  logic       edge_hit [3];
  logic       mismatch;
  logic       t0_wr;
  logic       t0_ovf;
  logic       priority_level_enable;
  logic       req_e0;
  logic       req_e1;
  logic       req_e2;
  logic       req_t0;
  logic       req_pc;
  logic       req_hi;
  logic       req_lo;
  logic       go_hi;
  logic       go_lo;
  logic [7:0] rbyte;
  logic [15:0] t0_sum;

  // Address decode used for the slave error; the read mux has its own case
  function automatic logic isp_mapped(input logic [7:0] a);
    return a inside {`ISP_OFF_RCPC, `ISP_OFF_MAIN, `ISP_OFF_SECOND, `ISP_OFF_THIRD,
                     `ISP_OFF_T0LO, `ISP_OFF_T0HI, `ISP_OFF_T0CTL, `ISP_OFF_PINS,
                     `ISP_OFF_SVC};
  endfunction

  // Masked byte update used by the RCPC, second and third registers
  function automatic isp_byte_t isp_merge(input isp_byte_t old, input isp_byte_t nw,
                                          input isp_byte_t m);
    return (old & ~m) | (nw & m);
  endfunction

  // Bus strobes: a transfer completes on the access edge with pready high
  always_comb begin
    wr      = psel & penable & state_reg.pready & pwrite;
    rd_done = psel & penable & state_reg.pready & ~pwrite;
    priority_level_enable    = state_reg.rcpc[`ISP_RCPC_PRIORITY_LEVEL_ENABLE];
  end

  // Edge detect on synchronised external inputs; select bit picks the edge
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (state_reg.second[`ISP_SEC_EDG0 - i]) begin
        edge_hit[i] = state_reg.sync2[i] & ~state_reg.prev[i];
      end else begin
        edge_hit[i] = ~state_reg.sync2[i] & state_reg.prev[i];
      end
    end
    // Mismatch against the value caught on the last pin read
    mismatch = |(state_reg.sync2[7:4] ^ state_reg.pc_latch);
  end

  // Timer: a bus write to either count byte suspends counting that cycle
  always_comb begin
    t0_wr  = wr & (paddr == `ISP_OFF_T0LO || paddr == `ISP_OFF_T0HI);
    t0_sum = 16'({state_reg.t0hi, state_reg.t0lo} + 17'h00001);
    t0_ovf = 1'b0;
    if (state_reg.t0ctl[`ISP_T0_RUN] && !t0_wr) begin
      if (isp_t0_mode_t'(state_reg.t0ctl[`ISP_T0_MODE]) == ISP_T0_16BIT) begin
        t0_ovf = {state_reg.t0hi, state_reg.t0lo} == 16'hFFFF;
      end else begin
        t0_ovf = state_reg.t0lo == 8'hFF;
      end
    end
  end

  // Requests are flag AND enable; priority routing only with levels on
  always_comb begin
    req_e0 = state_reg.main[`ISP_MAIN_E0IF] & state_reg.main[`ISP_MAIN_E0IE];
    req_e1 = state_reg.third[`ISP_THR_E1IF] & state_reg.third[`ISP_THR_E1IE];
    req_e2 = state_reg.third[`ISP_THR_E2IF] & state_reg.third[`ISP_THR_E2IE];
    req_t0 = state_reg.main[`ISP_MAIN_T0IF] & state_reg.main[`ISP_MAIN_TIMER0_IRQ_ENABLE];
    req_pc = state_reg.main[`ISP_MAIN_PCIF] & state_reg.main[`ISP_MAIN_PCIE];
    if (priority_level_enable) begin
      // Two levels; external zero has no priority bit
      req_hi = req_e0
             | (req_e1 & state_reg.third[`ISP_THR_E1IP])
             | (req_e2 & state_reg.third[`ISP_THR_E2IP])
             | (req_t0 & state_reg.second[`ISP_SEC_T0IP])
             | (req_pc & state_reg.second[`ISP_SEC_PCIP])
             | (periph_req & periph_prio);
      req_lo = (req_e1 & ~state_reg.third[`ISP_THR_E1IP])
             | (req_e2 & ~state_reg.third[`ISP_THR_E2IP])
             | (req_t0 & ~state_reg.second[`ISP_SEC_T0IP])
             | (req_pc & ~state_reg.second[`ISP_SEC_PCIP])
             | (periph_req & ~periph_prio);
      // Global bit acts as high enable, peripheral bit as low enable
      go_hi = state_reg.main[`ISP_MAIN_GIE] & req_hi & ~state_reg.in_high;
      go_lo = state_reg.main[`ISP_MAIN_GIE] & state_reg.main[`ISP_MAIN_PERIPHERAL_IRQ_ENABLE] & req_lo
            & ~state_reg.in_high & ~state_reg.in_low & ~go_hi;
    end else begin
      // Single level: priority bits ignored, one vector
      req_hi = req_e0 | req_e1 | req_e2 | req_t0 | req_pc
             | (periph_req & state_reg.main[`ISP_MAIN_PERIPHERAL_IRQ_ENABLE]);
      req_lo = 1'b0;
      go_hi  = state_reg.main[`ISP_MAIN_GIE] & req_hi & ~state_reg.in_high;
      go_lo  = 1'b0;
    end
  end

  // Read mux, reserved bits read zero
  always_comb begin
    case (paddr)
      `ISP_OFF_RCPC:   rbyte = state_reg.rcpc & 8'h9F;
      `ISP_OFF_MAIN:   rbyte = state_reg.main;
      `ISP_OFF_SECOND: rbyte = state_reg.second;
      `ISP_OFF_THIRD:  rbyte = state_reg.third;
      `ISP_OFF_T0LO:   rbyte = state_reg.t0lo;
      `ISP_OFF_T0HI:   rbyte = state_reg.t0hi;
      `ISP_OFF_T0CTL:  rbyte = {6'h00, state_reg.t0ctl};
      `ISP_OFF_PINS:   rbyte = state_reg.sync2;
      `ISP_OFF_SVC:    rbyte = 8'({state_reg.in_high, state_reg.in_low, state_reg.sp});
      default:         rbyte = 8'h00;
    endcase
  end

  // Next-state: bus writes first, then hardware clears, then hardware sets
  always_comb begin
    state_next       = state_reg;
    state_next.sync1 = pin_bank_b;
    state_next.sync2 = state_reg.sync1;
    state_next.prev  = state_reg.sync2[2:0];
    state_next.entry = 1'b0;
    state_next.wake  = 1'b0;

    // APB: answer in the first access cycle, drop ready after it
    state_next.pready = psel & ~penable;
    if (psel && !penable) begin
      state_next.prdata  = {24'h000000, rbyte};
      state_next.pslverr = ~isp_mapped(paddr);
    end

    if (wr) begin
      case (paddr)
        `ISP_OFF_RCPC: begin
          // Only the writable bits move
          state_next.rcpc = isp_merge(state_reg.rcpc, pwdata[7:0], `ISP_RCPC_WMASK);
        end
        `ISP_OFF_MAIN:   state_next.main   = pwdata[7:0];
        `ISP_OFF_SECOND: begin
          state_next.second = isp_merge(state_reg.second, pwdata[7:0], `ISP_SEC_MASK);
        end
        `ISP_OFF_THIRD: begin
          state_next.third = isp_merge(state_reg.third, pwdata[7:0], `ISP_THR_MASK);
        end
        `ISP_OFF_T0LO:   state_next.t0lo  = pwdata[7:0];
        `ISP_OFF_T0HI:   state_next.t0hi  = pwdata[7:0];
        `ISP_OFF_T0CTL:  state_next.t0ctl = pwdata[1:0];
        default: ;
      endcase
    end

    // Reading the pins ends the mismatch
    if (rd_done && paddr == `ISP_OFF_PINS) begin
      state_next.pc_latch = state_reg.sync2[7:4];
    end

    // Timer count
    if (state_reg.t0ctl[`ISP_T0_RUN] && !t0_wr) begin
      if (isp_t0_mode_t'(state_reg.t0ctl[`ISP_T0_MODE]) == ISP_T0_16BIT) begin
        state_next.t0lo = t0_sum[7:0];
        state_next.t0hi = t0_sum[15:8];
      end else begin
        state_next.t0lo = t0_sum[7:0];
      end
    end

    // Return from service: pop stack, reopen the level that was closed
    if (isr_return && (state_reg.in_high || state_reg.in_low)) begin
      if (state_reg.sp != '0) begin
        state_next.sp     = state_reg.sp - SP_W'(1);
        state_next.ret_pc = state_reg.stk[state_reg.sp - SP_W'(1)];
      end
      if (state_reg.in_high) begin
        state_next.in_high = 1'b0;
        state_next.main[`ISP_MAIN_GIE] = 1'b1;
      end else begin
        state_next.in_low = 1'b0;
        state_next.main[`ISP_MAIN_PERIPHERAL_IRQ_ENABLE] = 1'b1;
      end
    end

    // Entry: save context and close the taken level
    if (go_hi || go_lo) begin
      state_next.entry      = 1'b1;
      state_next.entry_high = go_hi;
      if (state_reg.sp < SP_W'(DEPTH)) begin
        // A full stack drops the push rather than wrap
        state_next.stk[state_reg.sp] = core_pc;
        state_next.sp = state_reg.sp + SP_W'(1);
      end
      state_next.sh_working_register = working_register;
      state_next.sh_stat = core_status;
      state_next.sh_bsr  = bank_select_register;
      if (go_hi) begin
        state_next.in_high = 1'b1;
        state_next.main[`ISP_MAIN_GIE] = 1'b0;
      end else begin
        state_next.in_low = 1'b1;
        state_next.main[`ISP_MAIN_PERIPHERAL_IRQ_ENABLE] = 1'b0;
      end
    end

    // Wake on any enabled request, whatever the global enable
    if (core_sleeping && (req_hi || req_lo)) begin
      state_next.wake = 1'b1;
    end

    // Hardware sets win over a clearing write in the same cycle
    if (edge_hit[0]) state_next.main[`ISP_MAIN_E0IF]  = 1'b1;
    if (edge_hit[1]) state_next.third[`ISP_THR_E1IF]  = 1'b1;
    if (edge_hit[2]) state_next.third[`ISP_THR_E2IF]  = 1'b1;
    if (t0_ovf)      state_next.main[`ISP_MAIN_T0IF]  = 1'b1;
    if (mismatch)    state_next.main[`ISP_MAIN_PCIF]  = 1'b1;
  end

  // State register; reset values are constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg        <= '0;
      state_reg.rcpc   <= `ISP_RCPC_RST;
      state_reg.second <= `ISP_SEC_RST;
      state_reg.third  <= `ISP_THR_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flops
  assign pready         = state_reg.pready;
  assign prdata         = state_reg.prdata;
  assign pslverr        = state_reg.pslverr;
  assign irq_entry      = state_reg.entry;
  assign irq_entry_high = state_reg.entry_high;
  assign core_wake      = state_reg.wake;
  assign return_pc      = state_reg.ret_pc;
  assign shadow_working_register    = state_reg.sh_working_register;
  assign shadow_status  = state_reg.sh_stat;
  assign shadow_bsr     = state_reg.sh_bsr;

  // Checks
  property p_rsv_zero;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && paddr == `ISP_OFF_RCPC) |=> (prdata[6:5] == 2'b00);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits not zero");

  property p_ro_flags;
    @(posedge pclk) disable iff (!presetn)
      wr |=> (state_reg.rcpc[3:2] == $past(state_reg.rcpc[3:2]));
  endproperty
  a_ro_flags: assert property (p_ro_flags) else $error("read-only flag changed");

  property p_edge_flag;
    @(posedge pclk) disable iff (!presetn)
      (state_reg.second[`ISP_SEC_EDG0] && state_reg.sync2[0] && !state_reg.prev[0])
        |=> state_reg.main[`ISP_MAIN_E0IF];
  endproperty
  a_edge_flag: assert property (p_edge_flag) else $error("rising edge missed");

  property p_vec_gie;
    @(posedge pclk) disable iff (!presetn)
      $rose(irq_entry) |-> $past(state_reg.main[`ISP_MAIN_GIE]);
  endproperty
  a_vec_gie: assert property (p_vec_gie) else $error("entry without global enable");

  property p_e0_high;
    @(posedge pclk) disable iff (!presetn)
      (priority_level_enable && req_e0 && state_reg.main[`ISP_MAIN_GIE] && !state_reg.in_high)
        |=> (irq_entry && irq_entry_high);
  endproperty
  a_e0_high: assert property (p_e0_high) else $error("ext zero not high");

  property p_t0_8bit;
    @(posedge pclk) disable iff (!presetn)
      (state_reg.t0ctl == 2'b01 && state_reg.t0lo == 8'hFF && !t0_wr)
        |=> (state_reg.main[`ISP_MAIN_T0IF] && state_reg.t0lo == 8'h00);
  endproperty
  a_t0_8bit: assert property (p_t0_8bit) else $error("8-bit overflow missed");

  property p_pc_flag;
    @(posedge pclk) disable iff (!presetn)
      mismatch |=> state_reg.main[`ISP_MAIN_PCIF];
  endproperty
  a_pc_flag: assert property (p_pc_flag) else $error("pin change missed");

  property p_push;
    @(posedge pclk) disable iff (!presetn)
      ((go_hi || go_lo) && !isr_return && state_reg.sp < SP_W'(DEPTH))
        |=> (state_reg.sp == $past(state_reg.sp) + SP_W'(1)
             && shadow_working_register == $past(working_register));
  endproperty
  a_push: assert property (p_push) else $error("context not saved");

  property p_wake;
    @(posedge pclk) disable iff (!presetn)
      (core_sleeping && req_e0) |=> core_wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
endmodule

// >>> verification/isp_core_model.sv
// Behavioural processor core that vectors on entry and returns after a service delay
`timescale 1ns/1ps
module isp_core_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        irq_entry,
  input  wire logic        core_wake,
  input  wire logic        sleep_req,
  input  wire logic [7:0]  svc_delay,
  output logic             core_sleeping,
  output logic             isr_return,
  output logic [20:0]      core_pc,
  output logic [7:0]       working_register,
  output logic [7:0]       core_status,
  output logic [7:0]       bank_select_register
);
  logic [44:0] ctx_q [$];
  int          wait_cnt;

  // Context moves only after an entry or at the return, so it is stable at the edge that saves it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_sleeping <= 1'b0;
      isr_return <= 1'b0;
      wait_cnt <= 0;
      {core_pc, working_register, core_status, bank_select_register} <= {21'h000100, 24'h5A3C11};
    end else begin
      // One-cycle return pulse, set in the cycle the service delay runs out
      isr_return <= !irq_entry && wait_cnt == 1;
      if (core_wake) begin
        core_sleeping <= 1'b0;
      end else if (sleep_req) begin
        core_sleeping <= 1'b1;
      end
      if (irq_entry) begin
        ctx_q.push_back({core_pc, working_register, core_status, bank_select_register});
        wait_cnt <= svc_delay;
        {core_pc, working_register, core_status, bank_select_register} <= {21'h000008, 24'($urandom)};
      end else if (wait_cnt == 1) begin
        // Slow or prompt return, as the bench sets the delay
        wait_cnt <= 0;
        {core_pc, working_register, core_status, bank_select_register} <= ctx_q.pop_back();
      end else if (wait_cnt > 1) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule

// >>> verification/irq_sources_and_priority_ctrl_bench.sv
// Self-checking bench for the interrupt source block against a register model
`timescale 1ns/1ps
`include "isp_consts.svh"
module irq_sources_and_priority_ctrl_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  pin_bank_b = 8'h00;
  logic        periph_req = 1'b0;
  logic        periph_prio = 1'b0;
  logic        sleep_req = 1'b0;
  logic [7:0]  svc_delay = 8'h14;
  logic        pready, pslverr, irq_entry, irq_entry_high, core_wake, core_sleeping, isr_return;
  logic [31:0] prdata;
  logic [20:0] core_pc, return_pc;
  logic [7:0]  working_register, core_status, bank_select_register;
  logic [7:0]  shadow_working_register, shadow_status, shadow_bsr;
  logic [7:0]  mdl [0:15];
  int          n_errors = 0;
  int          total_checks = 0;
  int          n_entries = 0;
  localparam int       T_SRC [6] = '{0, 1, 2, 1, 3, 3};
  localparam int       T_FIRE [6] = '{1, 1, 1, 1, 1, 0};
  localparam int       T_HIGH [6] = '{1, 0, 1, 1, 1, 0};
  localparam logic [7:0] T_RCPC [6] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] T_MAIN [6] = '{8'h90, 8'hC0, 8'h80, 8'h80, 8'hC0, 8'h80};
  localparam logic [7:0] T_THIRD [6] = '{8'h00, 8'h08, 8'h90, 8'h08, 8'h00, 8'h00};
  localparam logic [7:0] T0_LO [4] = '{8'hF8, 8'h00, 8'hF8, 8'hF8};
  localparam logic [7:0] T0_HI [4] = '{8'h00, 8'h00, 8'h00, 8'hFF};
  localparam logic [7:0] T0_CTL [4] = '{8'h01, 8'h01, 8'h03, 8'h03};
  localparam logic       T0_EXP [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  isp_ctrl #(.PC_W(21), .DEPTH(31)) u_isp_ctrl (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
    .pin_bank_b, .periph_req, .periph_prio, .core_sleeping, .isr_return, .core_pc,
    .working_register, .core_status, .bank_select_register, .irq_entry, .irq_entry_high,
    .core_wake, .return_pc, .shadow_working_register, .shadow_status, .shadow_bsr);
  isp_core_model u_isp_core_model (
    .pclk, .presetn, .irq_entry, .core_wake, .sleep_req, .svc_delay, .core_sleeping,
    .isr_return, .core_pc, .working_register, .core_status, .bank_select_register);

  // 125 MHz clock
  always #4 pclk = ~pclk;

  // Count vectoring pulses mid-cycle, where the registered output has settled
  always @(negedge pclk) begin
    if (irq_entry === 1'b1) n_entries++;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  // One transfer; upper write bits are random since only the low byte counts
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic [31:0] rv, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'($urandom), d};
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    // Request holds until an edge samples pready high; only the watchdog ends a hang
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("pready latency", 1, n);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      `ISP_OFF_RCPC:   return `ISP_RCPC_WMASK;
      `ISP_OFF_SECOND: return `ISP_SEC_MASK;
      `ISP_OFF_THIRD:  return `ISP_THR_MASK;
      default:         return 8'hFF;
    endcase
  endfunction

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rv;
    logic        e;
    apb(a, 1'b1, d, rv, e);
    mdl[a[5:2]] = (mdl[a[5:2]] & ~wmask(a)) | (d & wmask(a));
  endtask

  task automatic reg_rd(input logic [7:0] a);
    logic [31:0] rv;
    logic        e;
    apb(a, 1'b0, 8'h00, rv, e);
    chk($sformatf("register %h", a), {24'h0, mdl[a[5:2]]}, rv);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Index 3 stands for the peripheral request, other indexes for pins
  task automatic drive(input int i, input logic v);
    @(posedge pclk);
    if (i == 3) periph_req <= v;
    else pin_bank_b[i] <= v;
  endtask

  task automatic wait_for(input int sel, output logic seen);
    seen = 1'b0;
    repeat (60) begin
      @(negedge pclk);
      if ((sel == 0 && irq_entry === 1'b1) || (sel == 1 && isr_return === 1'b1) ||
          (sel == 2 && core_wake === 1'b1)) begin
        seen = 1'b1;
        break;
      end
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Cut a hung run short; the full sequence needs well under 10000 cycles
  initial begin
    #80000;
    n_errors++;
    close_out();
  end

  initial begin
    logic [31:0] v;
    logic        e;
    logic        seen;
    logic [44:0] ctx;
    logic [7:0]  a;
    int          k;
    int          i;
    int          f;
    void'($urandom(38224));
    for (k = 0; k < 16; k++) mdl[k] = 8'h00;
    mdl[0] = `ISP_RCPC_RST;
    mdl[2] = `ISP_SEC_RST;
    mdl[3] = `ISP_THR_RST;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, read-only and unimplemented bits, unmapped access
    reg_rd(`ISP_OFF_RCPC);
    reg_rd(`ISP_OFF_MAIN);
    reg_rd(`ISP_OFF_SECOND);
    reg_rd(`ISP_OFF_THIRD);
    reg_wr(`ISP_OFF_RCPC, 8'hFF);
    reg_rd(`ISP_OFF_RCPC);
    reg_wr(`ISP_OFF_RCPC, 8'h00);
    reg_rd(`ISP_OFF_RCPC);
    apb(8'h3C, 1'b0, 8'h00, v, e);
    chk("unmapped error", 1, e);
    chk("unmapped data", 0, v);
    $display("register access test done");
    // Each external input, both edge selections; wrong edge must not flag
    for (i = 0; i < 3; i++) begin
      a = (i == 0) ? `ISP_OFF_MAIN : `ISP_OFF_THIRD;
      f = (i == 0) ? 1 : i - 1;
      for (k = 0; k < 2; k++) begin
        reg_wr(`ISP_OFF_SECOND, k[0] ? 8'h75 : 8'h75 & ~(8'h40 >> i));
        drive(i, !k[0]);
        idle(6);
        reg_wr(`ISP_OFF_MAIN, 8'h80);
        reg_wr(`ISP_OFF_THIRD, 8'h00);
        drive(i, k[0]);
        idle(6);
        mdl[a[5:2]][f] = 1'b1;
        reg_rd(a);
        reg_wr(a, (i == 0) ? 8'h80 : 8'h00);
        drive(i, !k[0]);
        idle(6);
        reg_rd(a);
      end
    end
    chk("entries while disabled", 0, n_entries);
    $display("edge test done");
    // Entry routing per source and mode, context save and return
    for (k = 0; k < 6; k++) begin
      svc_delay <= k[0] ? 8'h28 : 8'h14;
      // Low peripheral priority in single-level mode must still vector high
      periph_prio <= ~k[2];
      reg_wr(`ISP_OFF_RCPC, T_RCPC[k]);
      reg_wr(`ISP_OFF_THIRD, T_THIRD[k]);
      reg_wr(`ISP_OFF_MAIN, T_MAIN[k]);
      ctx = {core_pc, working_register, core_status, bank_select_register};
      f = n_entries;
      drive(T_SRC[k], 1'b1);
      wait_for(0, seen);
      chk("entry", T_FIRE[k], seen);
      if (seen) begin
        chk("vector kind", T_HIGH[k], irq_entry_high);
        chk("shadows", ctx[23:0], {shadow_working_register, shadow_status, shadow_bsr});
      end
      reg_wr(`ISP_OFF_MAIN, 8'h00);
      reg_wr(`ISP_OFF_THIRD, 8'h00);
      drive(T_SRC[k], 1'b0);
      if (seen) begin
        wait_for(1, seen);
        @(negedge pclk);
        chk("return address", ctx[44:24], return_pc);
      end
      idle(4);
      chk("entry count", f + T_FIRE[k], n_entries);
    end
    $display("entry test done");
    // Wake from sleep with the global enable off: no vectoring
    reg_wr(`ISP_OFF_RCPC, 8'h80);
    reg_wr(`ISP_OFF_MAIN, 8'h00);
    reg_wr(`ISP_OFF_THIRD, 8'h10);
    @(posedge pclk);
    sleep_req <= 1'b1;
    @(posedge pclk);
    sleep_req <= 1'b0;
    f = n_entries;
    drive(2, 1'b1);
    wait_for(2, seen);
    chk("wake", 1, seen);
    idle(8);
    chk("entry without global enable", f, n_entries);
    reg_wr(`ISP_OFF_THIRD, 8'h00);
    drive(2, 1'b0);
    $display("wake test done");
    // Overflow in both widths, with and without wrap
    for (k = 0; k < 4; k++) begin
      reg_wr(`ISP_OFF_T0CTL, 8'h00);
      reg_wr(`ISP_OFF_MAIN, 8'h00);
      reg_wr(`ISP_OFF_T0LO, T0_LO[k]);
      reg_wr(`ISP_OFF_T0HI, T0_HI[k]);
      reg_wr(`ISP_OFF_T0CTL, T0_CTL[k]);
      idle(12);
      reg_wr(`ISP_OFF_T0CTL, 8'h00);
      mdl[1][2] = T0_EXP[k];
      reg_rd(`ISP_OFF_MAIN);
    end
    $display("timer test done");
    // Change on a random upper pin after re-latching the compare
    apb(`ISP_OFF_PINS, 1'b0, 8'h00, v, e);
    reg_wr(`ISP_OFF_MAIN, 8'h00);
    drive($urandom_range(7, 4), 1'b1);
    idle(6);
    mdl[1][0] = 1'b1;
    reg_rd(`ISP_OFF_MAIN);
    $display("pin change test done");
    close_out();
  end
endmodule
